// file: rtl/gpt_regs.svh
// register offsets, field positions, reset values and prescale counts
`ifndef GPT_REGS_SVH
`define GPT_REGS_SVH

// ==========================================================
// register index on the command port
`define GPT_REG_SA_CTL 4'h0
`define GPT_REG_SA_CNT 4'h1
`define GPT_REG_SA_PER 4'h2
`define GPT_REG_EV_CTL 4'h3
`define GPT_REG_EV_CNT 4'h4
`define GPT_REG_EV_PER 4'h5
`define GPT_REG_OD_CTL 4'h6
`define GPT_REG_OD_CNT 4'h7
`define GPT_REG_OD_PER 4'h8
`define GPT_REG_STATUS 4'h9

// ==========================================================
// control field positions
`define GPT_BIT_ON 15
`define GPT_BIT_SIDL 13
`define GPT_BIT_GATE 6
`define GPT_BIT_PS_HI 5
`define GPT_BIT_PS_LO 4
`define GPT_BIT_WIDE 3
`define GPT_BIT_SYNC 2
`define GPT_BIT_CS 1

// ==========================================================
// implemented bits per control register
`define GPT_MASK_SA 16'hA076
`define GPT_MASK_EV 16'hA07A
`define GPT_MASK_OD 16'hA072

// ==========================================================
// reset values
`define GPT_CTL_RST 16'h0000
`define GPT_CNT_RST 16'h0000
`define GPT_PER_RST 16'hFFFF

// ==========================================================
// prescale terminal counts (divide minus one)
`define GPT_PSC_TC_1 8'h00
`define GPT_PSC_TC_8 8'h07
`define GPT_PSC_TC_64 8'h3F
`define GPT_PSC_TC_256 8'hFF

`endif

// file: rtl/gpt_pkg.sv
// types shared by the timer block
package gpt_pkg;

    // ==========================================================
    // prescale select codes
    typedef enum logic [1:0]
    {
        GPT_PSC_1 = 2'b00,
        GPT_PSC_8 = 2'b01,
        GPT_PSC_64 = 2'b10,
        GPT_PSC_256 = 2'b11
    } gpt_psc_t;

endpackage

// file: rtl/gpt_prescale.sv
// prescale divider giving one tick per n advances
`timescale 1ns/1ps
`include "gpt_regs.svh"

module gpt_prescale
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_clr,
    input wire logic i_adv,
    input wire gpt_pkg::gpt_psc_t i_sel,
    output logic o_tick
);

    logic [7:0] cnt_r;
    wire [7:0] term;

    // ==========================================================
    // terminal count decode
    assign term = (i_sel == gpt_pkg::GPT_PSC_256) ? `GPT_PSC_TC_256 :
                  (i_sel == gpt_pkg::GPT_PSC_64) ? `GPT_PSC_TC_64 :
                  (i_sel == gpt_pkg::GPT_PSC_8) ? `GPT_PSC_TC_8 :
                  `GPT_PSC_TC_1;
    assign o_tick = i_adv & (cnt_r == term);

    // counts advances, clear wins over advance
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            cnt_r <= 8'h00;
        else if (i_clr)
            cnt_r <= 8'h00;
        else if (i_adv)
            cnt_r <= o_tick ? 8'h00 : 8'(cnt_r + 8'h01);
    end

endmodule

// file: rtl/gpt_count16.sv
// one 16-bit count word with load, clear and increment
`timescale 1ns/1ps
`include "gpt_regs.svh"

module gpt_count16
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_wr,
    input wire logic [15:0] i_wdata,
    input wire logic i_zero,
    input wire logic i_inc,
    output logic [15:0] o_count
);

    // ==========================================================
    // software load beats hardware wrap beats increment
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_count <= `GPT_CNT_RST;
        else if (i_wr)
            o_count <= i_wdata;
        else if (i_zero)
            o_count <= 16'h0000;
        else if (i_inc)
            o_count <= 16'(o_count + 16'h0001);
    end

endmodule

// file: rtl/gpt_top.sv
// standalone timer and pairable 16/32-bit timers with register port
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "gpt_regs.svh"

// Operation
// - on bit runs or halts standalone timer
// - idle-stop bit halts timer during idle
// - gating only under internal clock
// - prescale field divides by 1/8/64/256
// - standalone sync bit resamples external clock
// - source bit picks pin edges or internal
// - control write while running clears prescaler
// - event on period match or gate fall
// - only standalone timer may count unsynchronised
// - wide bit joins even and odd timers
// - wide mode ignores odd control bits
// - wide match reported on odd interrupt
// - odd period upper, even period lower
// - odd count upper, even count lower
// - even on bit runs whole wide pair
// - adc trigger from pair or odd timer
// - unimplemented control bits read zero
module gpt_top
#(
    parameter int ADDR_W = 4
)
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire logic i_idle,
    input wire logic i_ext_timer_clock_pin,
    input wire logic i_pair_ext_clock_pin_even,
    input wire logic i_pair_ext_clock_pin_odd,
    output logic o_standalone_irq,
    output logic o_even_irq,
    output logic o_odd_irq,
    output logic o_adc_trigger
);

    // ==========================================================
    // elaboration check
    generate
        if (ADDR_W < 4)
        begin : g_bad_addr
            $error("gpt_top: ADDR_W must be at least 4");
        end
    endgenerate

    // ==========================================================
    // register state
    logic [15:0] ctl_r [3];
    logic [15:0] sa_per_r;
    logic [15:0] ev_per_r;
    logic [15:0] od_per_r;
    logic [15:0] rdata_r;
    logic sa_irq_r;
    logic ev_irq_r;
    logic od_irq_r;
    logic adc_r;

    // per-timer wires, index 0 standalone, 1 even, 2 odd
    logic [15:0] ctl_eff [3];
    logic [2:0] adv;
    logic [2:0] tick;
    logic [2:0] gate_fall;
    logic [2:0] pin_lvl;
    logic [2:0] run;
    logic [2:0] psc_clr;
    logic [2:0] ctl_wr;
    logic [2:0] pins;

    // count words
    logic [15:0] sa_cnt;
    logic [15:0] ev_cnt;
    logic [15:0] od_cnt;

    // ==========================================================
    // address decode
    wire [3:0] idx = i_addr[3:0];
    wire hi_zero = (i_addr >> 4) == '0;
    wire sel_sa_ctl = hi_zero && idx == `GPT_REG_SA_CTL;
    wire sel_sa_cnt = hi_zero && idx == `GPT_REG_SA_CNT;
    wire sel_sa_per = hi_zero && idx == `GPT_REG_SA_PER;
    wire sel_ev_ctl = hi_zero && idx == `GPT_REG_EV_CTL;
    wire sel_ev_cnt = hi_zero && idx == `GPT_REG_EV_CNT;
    wire sel_ev_per = hi_zero && idx == `GPT_REG_EV_PER;
    wire sel_od_ctl = hi_zero && idx == `GPT_REG_OD_CTL;
    wire sel_od_cnt = hi_zero && idx == `GPT_REG_OD_CNT;
    wire sel_od_per = hi_zero && idx == `GPT_REG_OD_PER;
    wire sel_status = hi_zero && idx == `GPT_REG_STATUS;

    assign ctl_wr[0] = i_wr & sel_sa_ctl;
    assign ctl_wr[1] = i_wr & sel_ev_ctl;
    assign ctl_wr[2] = i_wr & sel_od_ctl;

    // ==========================================================
    // mode decode
    wire wide = ctl_r[1][`GPT_BIT_WIDE];

    // in wide mode the odd timer follows even control entirely
    assign ctl_eff[0] = ctl_r[0];
    assign ctl_eff[1] = ctl_r[1];
    assign ctl_eff[2] = wide ? ctl_r[1] : ctl_r[2];

    // pin order matches timer index
    assign pins = {i_pair_ext_clock_pin_odd,
                   i_pair_ext_clock_pin_even,
                   i_ext_timer_clock_pin};

    // ==========================================================
    // control and period registers
    // masks drop unimplemented positions so they read zero
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ctl_r[0] <= `GPT_CTL_RST;
            ctl_r[1] <= `GPT_CTL_RST;
            ctl_r[2] <= `GPT_CTL_RST;
        end
        else
        begin
            if (ctl_wr[0])
                ctl_r[0] <= i_wdata & `GPT_MASK_SA;
            if (ctl_wr[1])
                ctl_r[1] <= i_wdata & `GPT_MASK_EV;
            if (ctl_wr[2])
                ctl_r[2] <= i_wdata & `GPT_MASK_OD;
        end
    end

    // period words, no side effect on write
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sa_per_r <= `GPT_PER_RST;
            ev_per_r <= `GPT_PER_RST;
            od_per_r <= `GPT_PER_RST;
        end
        else
        begin
            if (i_wr && sel_sa_per)
                sa_per_r <= i_wdata;
            if (i_wr && sel_ev_per)
                ev_per_r <= i_wdata;
            if (i_wr && sel_od_per)
                od_per_r <= i_wdata;
        end
    end

    // ==========================================================
    // per-timer clock path: pin sync, edge, gate, prescaler
    generate
        for (genvar i = 0; i < 3; i++)
        begin : g_tmr
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic s4_r;
            wire [15:0] c = ctl_eff[i];
            wire ext_sel = c[`GPT_BIT_CS];
            // the pair always resamples; only index 0 may skip it
            wire sync_sel = (i == 0) ? c[`GPT_BIT_SYNC] : 1'b1;
            wire gated = ~ext_sel & c[`GPT_BIT_GATE];
            wire rise_fast = s2_r & ~s3_r;
            wire rise_sync = s3_r & ~s4_r;
            wire rise = sync_sel ? rise_sync : rise_fast;

            // pin synchroniser plus history for edges
            always_ff @(posedge i_clk or negedge i_nrst)
            begin
                if (!i_nrst)
                begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                    s4_r <= 1'b0;
                end
                else
                begin
                    s1_r <= pins[i];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    s4_r <= s3_r;
                end
            end

            // on bit and idle-stop decide whether time passes
            assign run[i] = c[`GPT_BIT_ON] &
                            ~(i_idle & c[`GPT_BIT_SIDL]);

            // pin edges or every clock, gate holds the count
            assign adv[i] = run[i] &
                            (ext_sel ? rise : (~gated | s2_r));
            assign gate_fall[i] = run[i] & gated & s3_r & ~s2_r;
            assign pin_lvl[i] = s2_r;

            // a running timer loses its partial prescale on rewrite
            assign psc_clr[i] = (ctl_wr[i] & ctl_r[i][`GPT_BIT_ON]) |
                                ~c[`GPT_BIT_ON];

            gpt_prescale u_psc
            (
                .i_clk(i_clk),
                .i_nrst(i_nrst),
                .i_clr(psc_clr[i]),
                .i_adv(adv[i]),
                .i_sel(gpt_pkg::gpt_psc_t'(c[`GPT_BIT_PS_HI:`GPT_BIT_PS_LO])),
                .o_tick(tick[i])
            );
        end
    endgenerate

    // ==========================================================
    // period compare
    wire sa_match = sa_cnt == sa_per_r;
    wire ev_match = ev_cnt == ev_per_r;
    wire od_match = od_cnt == od_per_r;
    wire wide_match = ev_match & od_match;
    wire ev_carry = ev_cnt == 16'hFFFF;

    // standalone wrap and event
    wire sa_zero = tick[0] & sa_match;
    wire sa_evt = sa_zero | gate_fall[0];

    // even word is the low half when joined
    wire ev_zero = tick[1] & (wide ? wide_match : ev_match);
    wire ev_evt = ~wide & ((tick[1] & ev_match) | gate_fall[1]);

    // odd word counts carries of the low half when joined
    wire od_inc = wide ? (tick[1] & ev_carry) : tick[2];
    wire od_zero = wide ? (tick[1] & wide_match) : (tick[2] & od_match);
    wire wide_evt = (tick[1] & wide_match) | gate_fall[1];
    wire solo_evt = (tick[2] & od_match) | gate_fall[2];
    wire od_evt = wide ? wide_evt : solo_evt;

    // converter trigger only from the period match of this pair
    wire adc_evt = wide ? (tick[1] & wide_match)
                        : (tick[2] & od_match);

    // ==========================================================
    // count words
    gpt_count16 u_sa_cnt
    (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_wr(i_wr & sel_sa_cnt),
        .i_wdata(i_wdata),
        .i_zero(sa_zero),
        .i_inc(tick[0]),
        .o_count(sa_cnt)
    );

    gpt_count16 u_ev_cnt
    (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_wr(i_wr & sel_ev_cnt),
        .i_wdata(i_wdata),
        .i_zero(ev_zero),
        .i_inc(tick[1]),
        .o_count(ev_cnt)
    );

    gpt_count16 u_od_cnt
    (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_wr(i_wr & sel_od_cnt),
        .i_wdata(i_wdata),
        .i_zero(od_zero),
        .i_inc(od_inc),
        .o_count(od_cnt)
    );

    // ==========================================================
    // event outputs, registered so they are clean one-cycle pulses
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sa_irq_r <= 1'b0;
            ev_irq_r <= 1'b0;
            od_irq_r <= 1'b0;
            adc_r <= 1'b0;
        end
        else
        begin
            sa_irq_r <= sa_evt;
            ev_irq_r <= ev_evt;
            od_irq_r <= od_evt;
            adc_r <= adc_evt;
        end
    end

    assign o_standalone_irq = sa_irq_r;
    assign o_even_irq = ev_irq_r;
    assign o_odd_irq = od_irq_r;
    assign o_adc_trigger = adc_r;

    // ==========================================================
    // read path
    // status shows live run state, pin levels and pairing
    wire [15:0] status = {9'h000, wide, pin_lvl, run};

    wire [15:0] rd_mux = sel_sa_ctl ? ctl_r[0] :
                         sel_sa_cnt ? sa_cnt :
                         sel_sa_per ? sa_per_r :
                         sel_ev_ctl ? ctl_r[1] :
                         sel_ev_cnt ? ev_cnt :
                         sel_ev_per ? ev_per_r :
                         sel_od_ctl ? ctl_r[2] :
                         sel_od_cnt ? od_cnt :
                         sel_od_per ? od_per_r :
                         sel_status ? status :
                         16'h0000;

    // data valid only the cycle after the strobe, zero otherwise
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            rdata_r <= 16'h0000;
        else if (i_rd)
            rdata_r <= rd_mux;
        else
            rdata_r <= 16'h0000;
    end

    assign o_rdata = rdata_r;

endmodule

// file: verification/gpt_top_checker.sv
// concurrent checks on the timer block's register port and event pins
`timescale 1ns/1ps
`include "gpt_regs.svh"

module gpt_top_checker
#(
    parameter int ADDR_W = 4
)
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic i_idle,
    input wire logic i_ext_timer_clock_pin,
    input wire logic i_pair_ext_clock_pin_even,
    input wire logic i_pair_ext_clock_pin_odd,
    input wire logic o_standalone_irq,
    input wire logic o_even_irq,
    input wire logic o_odd_irq,
    input wire logic o_adc_trigger
);
    // ==========================================================
    // shadows of written control, so checks need no design internals
    logic [15:0] sa_ctl_r;
    logic wide_r;
    logic sa_on;
    logic sa_stop;
    assign sa_on = sa_ctl_r[`GPT_BIT_ON];
    assign sa_stop = i_idle & sa_ctl_r[`GPT_BIT_SIDL];

    // only full writes matter here; unmapped writes never match
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sa_ctl_r <= 16'h0000;
            wide_r <= 1'b0;
        end
        else if (i_wr && i_addr == `GPT_REG_SA_CTL)
            sa_ctl_r <= i_wdata;
        else if (i_wr && i_addr == `GPT_REG_EV_CTL)
            wide_r <= i_wdata[`GPT_BIT_WIDE];
    end

    // ==========================================================
    // assertions
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    a_sa_readback: assert property ($past(i_rd) &&
        $past(i_addr) == `GPT_REG_SA_CTL |->
        o_rdata == ($past(sa_ctl_r) & `GPT_MASK_SA))
        else $error("standalone control readback wrong");
    a_ev_unused: assert property ($past(i_rd) &&
        $past(i_addr) == `GPT_REG_EV_CTL |->
        (o_rdata & ~`GPT_MASK_EV) == 16'h0000)
        else $error("even control unused bits set");
    a_od_unused: assert property ($past(i_rd) &&
        $past(i_addr) == `GPT_REG_OD_CTL |->
        (o_rdata & ~`GPT_MASK_OD) == 16'h0000)
        else $error("odd control unused bits set");
    a_unmapped_zero: assert property ($past(i_rd) &&
        $past(i_addr) > 9 |-> o_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_status_wide: assert property ($past(i_rd) &&
        $past(i_addr) == `GPT_REG_STATUS |-> o_rdata[6] == $past(wide_r))
        else $error("status wide flag wrong");
    a_wide_even: assert property (wide_r && $past(wide_r)
        |-> !o_even_irq)
        else $error("even event in wide mode");
    a_adc_odd: assert property (o_adc_trigger |-> o_odd_irq)
        else $error("adc trigger without odd event");
    a_off_quiet: assert property (!sa_on && !$past(sa_on) &&
        !$past(sa_on, 2) |-> !o_standalone_irq)
        else $error("standalone event while off");
    a_idle_quiet: assert property (sa_stop && $past(sa_stop) &&
        $past(sa_stop, 2) |-> !o_standalone_irq)
        else $error("standalone event while idle stopped");
endmodule

bind gpt_top gpt_top_checker #(.ADDR_W(ADDR_W)) gpt_top_checker_inst
(
    .i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_idle(i_idle),
    .i_ext_timer_clock_pin(i_ext_timer_clock_pin),
    .i_pair_ext_clock_pin_even(i_pair_ext_clock_pin_even),
    .i_pair_ext_clock_pin_odd(i_pair_ext_clock_pin_odd),
    .o_standalone_irq(o_standalone_irq), .o_even_irq(o_even_irq),
    .o_odd_irq(o_odd_irq), .o_adc_trigger(o_adc_trigger)
);

// file: verification/tb_gpt_top.sv
// self-checking bench for the timer block over its register port
`timescale 1ns/1ps
`include "gpt_regs.svh"

module tb_gpt_top;
    // ==========================================================
    // stimulus and observation
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_idle = 1'b0;
    logic pin = 1'b0;
    logic [15:0] o_rdata;
    logic [3:0] irq; // adc, odd, even, standalone
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0;
    int n;
    logic [15:0] a;
    logic [15:0] b;
    int dv [4] = '{1, 8, 64, 256};
    logic [15:0] msk [3] = '{`GPT_MASK_SA, `GPT_MASK_EV, `GPT_MASK_OD};
    logic [15:0] ext [2] = '{16'h8042, 16'h8046};

    gpt_top gpt_top_inst
    (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_idle(i_idle),
        .i_ext_timer_clock_pin(pin),
        .i_pair_ext_clock_pin_even(pin),
        .i_pair_ext_clock_pin_odd(1'b0),
        .o_standalone_irq(irq[0]), .o_even_irq(irq[1]),
        .o_odd_irq(irq[2]), .o_adc_trigger(irq[3])
    );

    // ==========================================================
    // clock and hang guard
    always #10 i_clk = ~i_clk;
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            mismatches++;
            close_out();
        end
    end

    // ==========================================================
    // access and compare tasks
    task automatic chk(input string nm, input logic [15:0] s,
        input logic [15:0] e);
        n_checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input logic [3:0] ad, input logic [15:0] d);
        @(posedge i_clk);
        i_addr <= ad;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] ad, output logic [15:0] v);
        @(posedge i_clk);
        i_addr <= ad;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        v = o_rdata;
    endtask

    // cycles until the chosen event pulse, -1 if none within lim
    task automatic wirq(input int sel, input int lim, output int c);
        c = -1;
        for (int k = 1; k <= lim; k++)
        begin
            @(posedge i_clk);
            #1;
            if (irq[sel] === 1'b1)
            begin
                c = k;
                break;
            end
        end
    endtask

    task automatic close_out();
        if (mismatches == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'b1;
        // reset values, then unused control bits dropped
        for (int i = 0; i < 3; i++)
        begin
            rd(4'(3 * i), a);
            chk("ctl reset", a, `GPT_CTL_RST);
            rd(4'(3 * i + 2), a);
            chk("per reset", a, `GPT_PER_RST);
            wr(4'(3 * i), 16'hFFFF);
            rd(4'(3 * i), a);
            chk("ctl mask", a, msk[i]);
            wr(4'(3 * i), 16'h0000);
        end
        wr(4'hC, 16'hFFFF);
        rd(4'hC, a);
        chk("unmapped", a, 16'h0000);
        wr(4'h9, 16'hFFFF);
        rd(4'h9, a);
        chk("status", a, 16'h0000);
        // undivided count, then halt
        wr(4'h2, 16'hFFFF);
        wr(4'h1, 16'h0010);
        wr(4'h0, 16'h8000);
        rd(4'h1, a);
        rd(4'h1, b);
        chk("count step", b - a, 16'h0002);
        wr(4'h0, 16'h0000);
        rd(4'h1, a);
        rd(4'h1, b);
        chk("halted", b, a);
        // every prescale code, period one; count starts below period
        wr(4'h2, 16'h0001);
        wr(4'h1, 16'h0000);
        for (int c = 0; c < 4; c++)
        begin
            wr(4'h0, 16'h8000 | (16'(c) << 4));
            wirq(0, 600, n);
            wirq(0, 600, n);
            chk("interval", 16'(n), 16'(2 * dv[c]));
        end
        // control rewrite mid-count restarts the divider
        wr(4'h0, 16'h8010);
        wirq(0, 40, n);
        repeat (5) @(posedge i_clk);
        wr(4'h0, 16'h8010);
        wirq(0, 40, n);
        chk("restart", 16'(n > 11), 16'h0001);
        // idle: runs unless idle stop set
        wr(4'h0, 16'h8000);
        i_idle <= 1'b1;
        wirq(0, 10, n);
        chk("idle run", 16'(n > 0), 16'h0001);
        wr(4'h0, 16'hA000);
        wirq(0, 5, n);
        wirq(0, 40, n);
        chk("idle stop", 16'(n), 16'hFFFF);
        @(posedge i_clk);
        i_idle <= 1'b0;
        wirq(0, 10, n);
        chk("idle leave", 16'(n > 0), 16'h0001);
        // gated accumulation and gate fall event
        wr(4'h0, 16'h0000);
        wr(4'h2, 16'hFFFF);
        wr(4'h1, 16'h0000);
        wr(4'h0, 16'h8040);
        repeat (10) @(posedge i_clk);
        rd(4'h1, a);
        chk("gate low", a, 16'h0000);
        @(posedge i_clk);
        pin <= 1'b1;
        repeat (20) @(posedge i_clk);
        pin <= 1'b0;
        wirq(0, 8, n);
        chk("gate fall", 16'(n > 0), 16'h0001);
        rd(4'h1, a);
        repeat (5) @(posedge i_clk);
        rd(4'h1, b);
        chk("gate hold", b, a);
        chk("gate span", 16'(a >= 18 && a <= 22), 16'h0001);
        // external edges, gate bit ignored, with and without sync
        for (int s = 0; s < 2; s++)
        begin
            wr(4'h0, 16'h0000);
            wr(4'h1, 16'h0000);
            wr(4'h0, ext[s]);
            repeat (5)
            begin
                @(posedge i_clk);
                pin <= 1'b1;
                repeat (3) @(posedge i_clk);
                pin <= 1'b0;
                repeat (3) @(posedge i_clk);
            end
            repeat (6) @(posedge i_clk);
            rd(4'h1, a);
            chk("edges", a, 16'h0005);
        end
        wr(4'h0, 16'h0000);
        // wide pair: odd control ignored, odd event, even silent
        wr(4'h3, 16'h0008);
        wr(4'h6, 16'h8030);
        wr(4'h5, 16'h0003);
        wr(4'h8, 16'h0000);
        wr(4'h4, 16'h0000);
        wr(4'h7, 16'h0000);
        wr(4'h3, 16'h8008);
        wirq(2, 20, n);
        wirq(2, 20, n);
        chk("wide interval", 16'(n), 16'h0004);
        wirq(3, 20, n);
        chk("wide adc", 16'(n > 0), 16'h0001);
        wirq(1, 20, n);
        chk("wide even", 16'(n), 16'hFFFF);
        rd(4'h9, a);
        chk("wide status", a, 16'h0046);
        // carry from lower into upper word
        wr(4'h3, 16'h0008);
        wr(4'h4, 16'hFFFF);
        wr(4'h7, 16'h0000);
        wr(4'h5, 16'h0000);
        wr(4'h8, 16'h0001);
        wr(4'h3, 16'h8008);
        wirq(2, 6, n);
        chk("carry", 16'(n > 0), 16'h0001);
        // independent halves, trigger only from odd
        wr(4'h3, 16'h0000);
        wr(4'h8, 16'h0001);
        wr(4'h6, 16'h8000);
        wirq(3, 10, n);
        wirq(3, 10, n);
        chk("odd adc", 16'(n), 16'h0002);
        wirq(1, 10, n);
        chk("even off", 16'(n), 16'hFFFF);
        wr(4'h6, 16'h0000);
        wr(4'h5, 16'h0001);
        wr(4'h4, 16'h0000);
        wr(4'h3, 16'h8000);
        wirq(1, 10, n);
        wirq(1, 10, n);
        chk("even run", 16'(n), 16'h0002);
        wirq(3, 10, n);
        chk("even no adc", 16'(n), 16'hFFFF);
        // even timer on pin edges; its sync bit is not implemented
        wr(4'h3, 16'h0000);
        wr(4'h4, 16'h0000);
        wr(4'h5, 16'hFFFF);
        wr(4'h3, 16'h8006);
        repeat (3)
        begin
            @(posedge i_clk);
            pin <= 1'b1;
            repeat (3) @(posedge i_clk);
            pin <= 1'b0;
            repeat (3) @(posedge i_clk);
        end
        repeat (6) @(posedge i_clk);
        rd(4'h4, a);
        chk("pair edges", a, 16'h0003);
        close_out();
    end
endmodule
